// ### slw_check.sv
`timescale 1ns/1ps
// How it works
// - Enabled matching access raises compare event: exact, address set or address plus data.
// - Debug interrupt only asserted while no higher priority exception pends.
// - Software-owned checks need no internal mode; hardware-owned need external mode.
// - Software-owned stack hit makes no compare event and no debug status flag.
// - Software-owned hit raises data storage or machine check by processor mode.
// - Hardware-owned hit sets external flag and enters debug halt like compares.
// - Stack hit counts only when stack pointer register formed the address.
// - Only accesses matching the limit compare in the resource's match mode are caught; skipping past goes unseen.
// - Software-owned hit aborts access, machine check saves offending instruction address.
// - Hardware-owned flag set after access completes, on the same edge as halt, watchpoint or both.
// - Hit on a stack resource triggers that resource's own action, except a hardware-owned hit beside a software-owned one.
// - Software-owned hit wins; aborted access yields no hardware event.
// - Read and write selection for both resources lives in first control register.
module slw_check
  import slw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire slw_reg_req_t reg_req,
  output logic [31:0]      reg_rdata,
  // Load/store unit
  input  wire slw_access_t acc,
  input  wire logic        acc_done,
  output logic             acc_abort,
  // Processor state
  input  wire logic        mchk_mode,
  input  wire logic        higher_prio_pending,
  // Exception and debug outputs
  output logic             dsi_req,
  output logic             mchk_req,
  output logic             debug_int,
  output logic             debug_halt_req,
  output logic             watchpoint,
  output logic             irq
);

  // Software-visible state
  logic [31:0]           debug_control_first;
  logic [31:0]           addr_compare_first;
  logic [31:0]           addr_compare_second;
  logic [31:0]           data_compare;
  logic [31:0]           addr_mask;
  logic [1:0]            debug_status_reg;
  logic [1:0]            external_debug_status;
  logic [NUM_EVENTS-1:0] event_status;
  logic [NUM_EVENTS-1:0] event_enable;
  logic [31:0]           machine_check_save_pc;

  // Hardware hits waiting for the access to complete
  logic [1:0]            hw_pending;

  // Compare decode for one resource
  function automatic logic addr_match(
    input logic [1:0]  mode,
    input logic [31:0] a,
    input logic [31:0] cmp,
    input logic [31:0] mask,
    input logic [31:0] d,
    input logic [31:0] dcmp
  );
    logic r;
    r = 1'b0;
    case (mode)
      MM_EXACT:    r = (a == cmp);
      MM_SET:      r = ((a & mask) == (cmp & mask));
      MM_ADDR_DAT: r = (a == cmp) && (d == dcmp);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  // Write strobe decode, shared by the compare and mask registers
  function automatic logic wr_sel(
    input slw_reg_req_t rq,
    input logic [7:0]   off
  );
    return rq.wr && (rq.addr == off);
  endfunction

  // Control fields
  logic       external_debug_mode;
  logic       internal_debug_mode;
  logic       evt_en;
  logic [1:0] rd_en;
  logic [1:0] wr_en;
  logic [1:0] slc_en;
  logic [1:0] hw_own;
  logic [1:0] mode0;
  logic [1:0] mode1;

  assign external_debug_mode    = debug_control_first[B_EDM];
  assign internal_debug_mode    = debug_control_first[B_IDM];
  assign evt_en = debug_control_first[B_EVT_EN];
  // Access type selection for both resources from one register
  assign rd_en  = {debug_control_first[B_RD_EN1],
                   debug_control_first[B_RD_EN0]};
  assign wr_en  = {debug_control_first[B_WR_EN1],
                   debug_control_first[B_WR_EN0]};
  assign slc_en = {debug_control_first[B_SLC_EN1],
                   debug_control_first[B_SLC_EN0]};
  assign hw_own = {debug_control_first[B_HW_OWN1],
                   debug_control_first[B_HW_OWN0]};
  assign mode0  = debug_control_first[B_MODE0_LO +: 2];
  assign mode1  = debug_control_first[B_MODE1_LO +: 2];

  // Raw hits per resource
  logic [1:0] hit;

  assign hit[0] = acc.valid
                  && ((acc.load && rd_en[0]) || (acc.store && wr_en[0]))
                  && addr_match(mode0, acc.addr, addr_compare_first,
                                addr_mask, acc.data, data_compare);
  assign hit[1] = acc.valid
                  && ((acc.load && rd_en[1]) || (acc.store && wr_en[1]))
                  && addr_match(mode1, acc.addr, addr_compare_second,
                                addr_mask, acc.data, data_compare);

  // Classify each hit by checking mode and owner
  logic [1:0] stack_hit;
  logic [1:0] sw_viol;
  logic [1:0] hw_viol;
  logic [1:0] plain_hit;
  logic       any_sw;

  // Stack pointer qualification; address skips past the limit never hit
  assign stack_hit = hit & slc_en & {2{acc.sp_based}};
  // Software-owned checking runs whatever the debug modes
  assign sw_viol   = stack_hit & ~hw_own;
  // Hardware-owned checking only under external debug mode
  assign hw_viol   = stack_hit & hw_own & {2{external_debug_mode && evt_en}};
  // Without stack checking the resource is an ordinary watchpoint
  assign plain_hit = hit & ~slc_en
                     & {2{evt_en && (external_debug_mode || internal_debug_mode)}};
  // Any one software resource is enough to act
  assign any_sw    = |sw_viol;

  // Abort stops the access before it completes
  assign acc_abort = any_sw;

  // Hardware-facing hits: external mode routes plain hits here too
  logic [1:0] hw_hit;
  assign hw_hit = hw_viol | (plain_hit & {2{external_debug_mode}});

  // Register write decode
  logic wr_ctl;
  logic wr_dbs;
  logic wr_edbs;
  logic wr_clr;
  logic wr_ena;

  assign wr_ctl  = reg_req.wr && (reg_req.addr == OFF_DEBUG_CONTROL_FIRST);
  assign wr_dbs  = reg_req.wr && (reg_req.addr == OFF_DEBUG_STATUS_REG);
  assign wr_edbs = reg_req.wr
                   && (reg_req.addr == OFF_EXTERNAL_DEBUG_STATUS);
  assign wr_clr  = reg_req.wr && (reg_req.addr == OFF_EVENT_CLEAR);
  assign wr_ena  = reg_req.wr && (reg_req.addr == OFF_EVENT_ENABLE);

  // Compare word strobes
  logic wr_ac1;
  logic wr_ac2;
  logic wr_dcmp;
  logic wr_msk;
  assign wr_ac1  = wr_sel(reg_req, OFF_ADDR_COMPARE_FIRST);
  assign wr_ac2  = wr_sel(reg_req, OFF_ADDR_COMPARE_SECOND);
  assign wr_dcmp = wr_sel(reg_req, OFF_DATA_COMPARE);
  assign wr_msk  = wr_sel(reg_req, OFF_ADDR_MASK);

  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      debug_control_first <= RST_CONTROL;
      addr_compare_first  <= RST_WORD;
      addr_compare_second <= RST_WORD;
      data_compare        <= RST_WORD;
      addr_mask           <= RST_MASK;
      event_enable        <= '0;
    end else begin
      if (wr_ctl) begin
        debug_control_first <= reg_req.wdata;
      end
      if (wr_ac1) begin
        addr_compare_first <= reg_req.wdata;
      end
      if (wr_ac2) begin
        addr_compare_second <= reg_req.wdata;
      end
      if (wr_dcmp) begin
        data_compare <= reg_req.wdata;
      end
      if (wr_msk) begin
        addr_mask <= reg_req.wdata;
      end
      if (wr_ena) begin
        event_enable <= reg_req.wdata[NUM_EVENTS-1:0];
      end
    end
  end

  // Internal-mode status; software stack hits never land here
  logic [1:0] next_dbs_set;
  assign next_dbs_set = plain_hit & {2{internal_debug_mode && !external_debug_mode}};

  // Write-one-to-clear, but a new hit in the same cycle survives
  always_ff @(posedge clk) begin
    if (reset) begin
      debug_status_reg <= 2'h0;
    end else begin
      debug_status_reg <= (debug_status_reg
                           & ~(wr_dbs ? reg_req.wdata[1:0] : 2'h0))
                          | next_dbs_set;
    end
  end

  // Limitation: one access in flight only; a new valid access
  // overwrites hits that still wait for their completion
  // Hold hardware hits until the access completes; abort discards them
  always_ff @(posedge clk) begin
    if (reset) begin
      hw_pending <= 2'h0;
    end else if (any_sw) begin
      hw_pending <= 2'h0;
    end else if (acc_done) begin
      hw_pending <= 2'h0;
    end else if (acc.valid) begin
      hw_pending <= hw_hit;
    end
  end

  // Completion of a flagged access
  logic hw_fire;
  assign hw_fire = acc_done && (|hw_pending) && !any_sw;

  // External status flag set only once the access has finished
  always_ff @(posedge clk) begin
    if (reset) begin
      external_debug_status <= 2'h0;
    end else begin
      external_debug_status <= (external_debug_status
                                & ~(wr_edbs ? reg_req.wdata[1:0] : 2'h0))
                               | (hw_fire ? hw_pending : 2'h0);
    end
  end

  // Hardware actions chosen by the debugger
  logic halt_en;
  logic wp_en;
  assign halt_en = debug_control_first[B_HALT_EN];
  assign wp_en   = debug_control_first[B_WP_EN];

  // Halt and watchpoint pulses, one cycle after completion
  always_ff @(posedge clk) begin
    if (reset) begin
      debug_halt_req <= 1'b0;
      watchpoint     <= 1'b0;
    end else begin
      debug_halt_req <= hw_fire && halt_en;
      watchpoint     <= hw_fire && wp_en;
    end
  end

  // Registered so the core sees one clean pulse per abort
  // Software exception: mode picks data storage or machine check
  always_ff @(posedge clk) begin
    if (reset) begin
      dsi_req  <= 1'b0;
      mchk_req <= 1'b0;
    end else begin
      dsi_req  <= any_sw && !mchk_mode;
      mchk_req <= any_sw && mchk_mode;
    end
  end

  // Data storage mode leaves the last saved address intact
  // Save the offending instruction address on a machine check
  always_ff @(posedge clk) begin
    if (reset) begin
      machine_check_save_pc <= RST_WORD;
    end else if (any_sw && mchk_mode) begin
      machine_check_save_pc <= acc.pc;
    end
  end

  // Debug interrupt waits behind any higher priority exception
  always_ff @(posedge clk) begin
    if (reset) begin
      debug_int <= 1'b0;
    end else begin
      debug_int <= (|debug_status_reg) && internal_debug_mode && !external_debug_mode
                   && !higher_prio_pending;
    end
  end

  // Sticky events; a set in the clear cycle wins
  logic [NUM_EVENTS-1:0] next_evt_set;
  always_comb begin
    next_evt_set             = '0;
    next_evt_set[E_DBG_HIT]  = |next_dbs_set;
    next_evt_set[E_SW_VIOL]  = any_sw;
    next_evt_set[E_HW_VIOL]  = hw_fire && (|(hw_pending & slc_en));
    next_evt_set[E_HALT]     = hw_fire;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      event_status <= '0;
    end else begin
      event_status <= (event_status
                       & ~(wr_clr ? reg_req.wdata[NUM_EVENTS-1:0] : '0))
                      | next_evt_set;
    end
  end

  // Level interrupt from enabled sticky events
  assign irq = |(event_status & event_enable);

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= RST_WORD;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFF_DEBUG_CONTROL_FIRST:   reg_rdata <= debug_control_first;
        OFF_ADDR_COMPARE_FIRST:    reg_rdata <= addr_compare_first;
        OFF_ADDR_COMPARE_SECOND:   reg_rdata <= addr_compare_second;
        OFF_DATA_COMPARE:          reg_rdata <= data_compare;
        OFF_ADDR_MASK:             reg_rdata <= addr_mask;
        OFF_DEBUG_STATUS_REG:      reg_rdata <= {30'h0, debug_status_reg};
        OFF_EXTERNAL_DEBUG_STATUS:
          reg_rdata <= {30'h0, external_debug_status};
        OFF_EVENT_STATUS:          reg_rdata <= {28'h0, event_status};
        OFF_EVENT_ENABLE:          reg_rdata <= {28'h0, event_enable};
        OFF_MACHINE_CHECK_SAVE_PC: reg_rdata <= machine_check_save_pc;
        default:                   reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      // Data stand only in the cycle after the read strobe
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // slw_check

// ### slw_pkg.sv
package slw_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFF_DEBUG_CONTROL_FIRST   = 8'h00;
  localparam logic [7:0] OFF_ADDR_COMPARE_FIRST    = 8'h04;
  localparam logic [7:0] OFF_ADDR_COMPARE_SECOND   = 8'h08;
  localparam logic [7:0] OFF_DATA_COMPARE          = 8'h0c;
  localparam logic [7:0] OFF_ADDR_MASK             = 8'h10;
  localparam logic [7:0] OFF_DEBUG_STATUS_REG      = 8'h14;
  localparam logic [7:0] OFF_EXTERNAL_DEBUG_STATUS = 8'h18;
  localparam logic [7:0] OFF_EVENT_STATUS          = 8'h1c;
  localparam logic [7:0] OFF_EVENT_CLEAR           = 8'h20;
  localparam logic [7:0] OFF_EVENT_ENABLE          = 8'h24;
  localparam logic [7:0] OFF_MACHINE_CHECK_SAVE_PC = 8'h28;

  // Field positions in debug_control_first
  localparam int B_RD_EN0   = 0;   // resource 0 read accesses
  localparam int B_WR_EN0   = 1;   // resource 0 write accesses
  localparam int B_RD_EN1   = 2;
  localparam int B_WR_EN1   = 3;
  localparam int B_EVT_EN   = 4;   // compare events enabled
  localparam int B_SLC_EN0  = 8;   // stack limit checking, resource 0
  localparam int B_SLC_EN1  = 9;
  localparam int B_HW_OWN0  = 10;  // resource 0 owned by hardware
  localparam int B_HW_OWN1  = 11;
  localparam int B_WP_EN    = 12;  // hardware hit signals a watchpoint
  localparam int B_HALT_EN  = 13;  // hardware hit enters debug halt
  localparam int B_MODE0_LO = 16;  // resource 0 match mode, 2 bits
  localparam int B_MODE1_LO = 18;  // resource 1 match mode, 2 bits
  localparam int B_IDM      = 30;  // internal_debug_mode
  localparam int B_EDM      = 31;  // external_debug_mode

  // Event status bits
  localparam int E_DBG_HIT  = 0;
  localparam int E_SW_VIOL  = 1;
  localparam int E_HW_VIOL  = 2;
  localparam int E_HALT     = 3;
  localparam int NUM_EVENTS = 4;

  // Reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] RST_MASK    = 32'hffff_ffff;

  // Address match modes
  typedef enum logic [1:0] {
    MM_EXACT    = 2'h0,
    MM_SET      = 2'h1,
    MM_ADDR_DAT = 2'h2,
    MM_OFF      = 2'h3
  } slw_match_t;

  // One load or store presented by the load/store unit
  typedef struct packed {
    logic        valid;
    logic        load;
    logic        store;
    logic        sp_based;   // stack_pointer_gpr used as base or index
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] pc;
  } slw_access_t;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } slw_reg_req_t;

endpackage

// ### slw_check_sva.sv
`timescale 1ns/1ps
module slw_check_sva
  import slw_pkg::*;
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         reset,
  // Register port
  input wire slw_reg_req_t reg_req,
  input wire logic [31:0]  reg_rdata,
  // Load/store side and processor state
  input wire slw_access_t  acc,
  input wire logic         acc_done,
  input wire logic         acc_abort,
  input wire logic         mchk_mode,
  input wire logic         higher_prio_pending,
  // Exception and debug outputs
  input wire logic         dsi_req,
  input wire logic         mchk_req,
  input wire logic         debug_int,
  input wire logic         debug_halt_req,
  input wire logic         watchpoint,
  input wire logic         irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Abort only for a live stack-pointer access
  abort_needs_sp_a: assert property (
    acc_abort |-> acc.valid && acc.sp_based) else $error("abort cause");
  sw_mode_pick_a: assert property (
    acc_abort |=> mchk_req == $past(mchk_mode) && dsi_req != $past(mchk_mode))
    else $error("wrong exception kind");
  excp_cause_a: assert property (
    (dsi_req || mchk_req) |-> $past(acc_abort)) else $error("stray exception");
  // Pending hardware hit must die with the abort
  abort_no_hw_a: assert property (
    acc_abort |=> (!debug_halt_req && !watchpoint)[*2])
    else $error("hw event after abort");
  halt_after_done_a: assert property (
    debug_halt_req |-> $past(acc_done)) else $error("halt before done");
  wp_after_done_a: assert property (
    watchpoint |-> $past(acc_done)) else $error("watchpoint before done");
  dbg_int_block_a: assert property (
    debug_int |-> !$past(higher_prio_pending)) else $error("debug int blocked");
  rdata_idle_a: assert property (
    !$past(reg_req.rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");

  cover property (acc_abort && mchk_mode);
  cover property (acc_abort && !mchk_mode);
  cover property (debug_halt_req && watchpoint);
  cover property (debug_int);
endmodule // slw_check_sva

bind slw_check slw_check_sva slw_check_sva_inst (
  .clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .acc(acc), .acc_done(acc_done), .acc_abort(acc_abort),
  .mchk_mode(mchk_mode), .higher_prio_pending(higher_prio_pending),
  .dsi_req(dsi_req), .mchk_req(mchk_req), .debug_int(debug_int),
  .debug_halt_req(debug_halt_req), .watchpoint(watchpoint), .irq(irq)
);

// ### slw_lsu_model.sv
`timescale 1ns/1ps
module slw_lsu_model
  import slw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bench command
  input  wire logic        start,
  input  wire slw_access_t cmd,
  input  wire logic [3:0]  lat,
  output logic             busy,
  // Access side
  input  wire logic        acc_abort,
  output slw_access_t      acc,
  output logic             acc_done
);
  logic [3:0] cnt;

  // One access in flight; an aborted one never completes
  always_ff @(posedge clk) begin
    if (reset) begin
      acc      <= '0;
      acc_done <= 1'b0;
      busy     <= 1'b0;
      cnt      <= 4'h0;
    end else begin
      acc_done  <= 1'b0;
      acc.valid <= 1'b0;
      // Idle fields churn so stale values never pass as held
      acc.addr  <= ~acc.addr;
      acc.data  <= ~acc.data;
      if (start) begin
        acc  <= cmd;
        busy <= 1'b1;
        cnt  <= lat;
      end else if (busy && acc.valid && acc_abort) begin
        busy <= 1'b0;
      end else if (busy && cnt == 4'h0) begin
        acc_done <= 1'b1;
        busy     <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // slw_lsu_model

// ### slw_check_tb.sv
`timescale 1ns/1ps
module slw_check_tb;
  import slw_pkg::*;
  localparam logic [31:0] LIM = 32'h0000_2000;
  localparam logic [31:0] TOP = 32'h0000_3ffc;
  localparam logic [31:0] WAT = 32'h0000_5a00;
  localparam logic [31:0] MSK = 32'hffff_ff00;
  localparam logic [31:0] DV  = 32'h1234_5678;
  logic         clk, reset, start, busy, hpp, mchk_mode, acc_done, acc_abort;
  logic         dsi_req, mchk_req, debug_int, debug_halt_req, watchpoint, irq;
  logic         ab, ha, wq, dx, mx;
  logic [3:0]   lat;
  logic [15:0]  rnd;
  logic [31:0]  reg_rdata, rv, pcv, a, dd, ctl;
  slw_reg_req_t req;
  slw_access_t  cmd, acc;
  slw_match_t   m;
  int           error_cnt = 0;
  int           n_checks = 0;

  slw_check slw_check_inst (
    .clk(clk), .reset(reset), .reg_req(req), .reg_rdata(reg_rdata),
    .acc(acc), .acc_done(acc_done), .acc_abort(acc_abort),
    .mchk_mode(mchk_mode), .higher_prio_pending(hpp),
    .dsi_req(dsi_req), .mchk_req(mchk_req), .debug_int(debug_int),
    .debug_halt_req(debug_halt_req), .watchpoint(watchpoint), .irq(irq));
  slw_lsu_model slw_lsu_model_inst (
    .clk(clk), .reset(reset), .start(start), .cmd(cmd), .lat(lat),
    .busy(busy), .acc_abort(acc_abort), .acc(acc), .acc_done(acc_done));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] bt(input int b);
    return 32'h1 << b;
  endfunction
  // Expected hit of the plain watchpoint on resource 0
  function automatic logic exp_hit(slw_match_t mm, logic [31:0] x, y);
    case (mm)
      MM_EXACT:    return x == WAT;
      MM_SET:      return (x & MSK) == (WAT & MSK);
      MM_ADDR_DAT: return x == WAT && y == DV;
      default:     return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, ad, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    req <= {1'b0, 1'b1, ad, 32'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  // One access; collects what the block answered until it settles
  task automatic go(input logic [31:0] ad, input logic sp, ld, mk,
                    input logic [31:0] d);
    int tail;
    tail = 0;
    pcv = pcv + 32'h4;
    @(posedge clk);
    cmd <= {1'b1, ld, !ld, sp, ad, d, pcv};
    mchk_mode <= mk;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    ab = acc_abort;
    {ha, wq, dx, mx} = 4'h0;
    for (int i = 0; i < 20 && tail < 2; i++) begin
      @(negedge clk);
      {ha, wq} = {ha | debug_halt_req, wq | watchpoint};
      {dx, mx} = {dx | dsi_req, mx | mchk_req};
      if (!busy)
        tail++;
    end
    if (tail < 2) begin
      error_cnt++;
      $display("BAD %0t access hung", $time);
      tally_and_finish();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {reset, req, cmd, start, lat} = {1'b1, 42'h0, 100'h0, 1'b0, 4'h0};
    {mchk_mode, hpp, rnd, pcv} = {1'b0, 1'b0, 16'h082a, 32'h0000_1000};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values, unmapped and read-only places
    rd(OFF_DEBUG_CONTROL_FIRST);
    chk(rv, RST_CONTROL);
    rd(OFF_ADDR_MASK);
    chk(rv, RST_MASK);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c);
    chk(rv, 32'h0);
    wr(OFF_MACHINE_CHECK_SAVE_PC, 32'hffff_ffff);
    rd(OFF_MACHINE_CHECK_SAVE_PC);
    chk(rv, 32'h0);
    // Software-owned limit on resource 0, no internal mode
    wr(OFF_ADDR_COMPARE_FIRST, LIM);
    ctl = bt(B_RD_EN0) | bt(B_WR_EN0) | bt(B_SLC_EN0) | bt(B_EVT_EN);
    wr(OFF_DEBUG_CONTROL_FIRST, ctl);
    wr(OFF_EVENT_ENABLE, bt(E_SW_VIOL));
    go(LIM, 1'b1, 1'b1, 1'b1, DV);
    chk(32'({ab, mx, dx, ha}), 32'hc);
    chk(32'(irq), 32'h1);
    rd(OFF_MACHINE_CHECK_SAVE_PC);
    chk(rv, pcv);
    rd(OFF_DEBUG_STATUS_REG);
    chk(rv, 32'h0);
    wr(OFF_EVENT_CLEAR, bt(E_SW_VIOL));
    @(negedge clk);
    chk(32'(irq), 32'h0);
    wr(OFF_EVENT_ENABLE, 32'h0);
    // Random neighbours of the limit, with and without the stack pointer
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      lat <= rnd[9:8];
      a = LIM + (rnd[1:0] == 2'h1 ? 32'h4 : rnd[1:0] == 2'h2 ? -32'h4 : 32'h0);
      go(a, rnd[2], rnd[3], rnd[4], DV);
      dd = 32'(rnd[2] && a == LIM);
      chk(32'({ab, mx, dx}), {29'h0, dd[0], dd[0] & rnd[4], dd[0] & !rnd[4]});
    end
    chk(32'(irq), 32'h0);
    // Loads only: a store at the limit passes
    wr(OFF_DEBUG_CONTROL_FIRST, bt(B_RD_EN0) | bt(B_SLC_EN0));
    go(LIM, 1'b1, 1'b0, 1'b1, DV);
    chk(32'(ab), 32'h0);
    // Hardware-owned resource 1 beside software-owned resource 0
    wr(OFF_ADDR_COMPARE_SECOND, TOP);
    ctl = bt(B_RD_EN1) | bt(B_WR_EN1) | bt(B_SLC_EN1) | bt(B_HW_OWN1);
    ctl = ctl | bt(B_EVT_EN) | bt(B_WP_EN) | bt(B_HALT_EN);
    wr(OFF_DEBUG_CONTROL_FIRST, ctl);
    go(TOP, 1'b1, 1'b1, 1'b1, DV);
    chk(32'({ab, ha, wq}), 32'h0);
    wr(OFF_DEBUG_CONTROL_FIRST, ctl | bt(B_EDM) | bt(B_RD_EN0) | bt(B_SLC_EN0));
    lat <= 4'h3;
    go(TOP, 1'b1, 1'b0, 1'b1, DV);
    chk(32'({ab, ha, wq}), 32'h3);
    rd(OFF_EXTERNAL_DEBUG_STATUS);
    chk(rv, 32'h2);
    go(LIM, 1'b1, 1'b1, 1'b0, DV);
    chk(32'({ab, dx, ha}), 32'h6);
    wr(OFF_ADDR_COMPARE_SECOND, LIM);
    go(LIM, 1'b1, 1'b1, 1'b1, DV);
    chk(32'({ab, mx, ha, wq}), 32'hc);
    // Plain watchpoint on resource 0 under internal mode, every match mode
    wr(OFF_ADDR_COMPARE_FIRST, WAT);
    wr(OFF_ADDR_MASK, MSK);
    wr(OFF_DATA_COMPARE, DV);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      m = slw_match_t'(i % 4);
      a = WAT ^ (rnd[0] ? 32'h10 : 32'h0);
      dd = rnd[1] ? DV : ~DV;
      wr(OFF_DEBUG_STATUS_REG, 32'h3);
      ctl = bt(B_RD_EN0) | bt(B_EVT_EN) | bt(B_IDM);
      wr(OFF_DEBUG_CONTROL_FIRST, ctl | (32'(m) << B_MODE0_LO));
      go(a, 1'b1, 1'b1, 1'b0, dd);
      rd(OFF_DEBUG_STATUS_REG);
      chk(rv, 32'(exp_hit(m, a, dd)));
      chk(32'({ab, debug_int}), 32'(exp_hit(m, a, dd)));
    end
    // Back to exact mode; the loop ended with matching switched off
    wr(OFF_DEBUG_CONTROL_FIRST, ctl);
    go(WAT, 1'b0, 1'b1, 1'b0, DV);
    @(posedge clk);
    hpp <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(debug_int), 32'h0);
    @(posedge clk);
    hpp <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(debug_int), 32'h1);
    tally_and_finish();
  end
endmodule // slw_check_tb
